/* ttc_pkg.sv */
// Purpose: Shared constants and types of the thermal throttle control block.
// Assumes: 100 MHz core clock, APB register access with 32-bit data.
// Notes:   Register offsets are byte addresses of aligned words.
package ttc_pkg;
  // Clock
  localparam int          CLOCK_PERIOD_NS  = 10;
  // Register byte offsets
  localparam logic [7:0]  ADDR_THROTTLE    = 8'h00;
  localparam logic [7:0]  ADDR_AUTO        = 8'h04;
  localparam logic [7:0]  ADDR_OP_REQUEST  = 8'h08;
  localparam logic [7:0]  ADDR_OP_THERMAL  = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS      = 8'h10;
  localparam logic [7:0]  ADDR_EVENTS      = 8'h14;
  localparam logic [7:0]  ADDR_DIODE       = 8'h18;
  localparam logic [7:0]  ADDR_IDEALITY    = 8'h1C;
  // Throttle control fields
  localparam int          THR_DEMAND_BIT   = 4;
  localparam int          THR_DUTY_LSB     = 1;
  localparam int          THR_DUTY_MSB     = 3;
  // Auto control fields
  localparam int          AUTO_CLK_BIT     = 0;
  localparam int          AUTO_OP_BIT      = 1;
  localparam int          AUTO_IRQ_ON_BIT  = 2;
  localparam int          AUTO_IRQ_OFF_BIT = 3;
  // Event flag fields
  localparam int          EVT_ON_BIT       = 0;
  localparam int          EVT_OFF_BIT      = 1;
  // Values after reset
  localparam logic [4:0]  THROTTLE_RESET   = 5'h00;
  localparam logic [3:0]  AUTO_RESET       = 4'h3;
  localparam logic [7:0]  OP_REQUEST_RESET = 8'h0C;
  localparam logic [7:0]  OP_THERMAL_RESET = 8'h06;
  // Modulation
  localparam logic [2:0]  AUTO_DUTY        = 3'h4;
  localparam logic [15:0] SLOT_BASE        = 16'h0400;
  localparam logic [15:0] SLOT_STEP        = 16'h0010;
  // Reference ideality 1.01 in hundredths
  localparam logic [15:0] REF_IDEALITY     = 16'h0065;
  // Trip release dwell
  localparam int          HYST_TIME_US     = 10;
  localparam int          HYST_CYCLES      =
    (HYST_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // Dwell before clock modulation joins an operating point throttle
  localparam int          ESCALATE_TIME_US = 200;
  localparam int          ESCALATE_CYCLES  =
    (ESCALATE_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [2:0] {
    TTC_IDLE,
    TTC_DEMAND,
    TTC_AUTO_MOD,
    TTC_AUTO_OP,
    TTC_AUTO_BOTH
  } ttc_state_t;
endpackage : ttc_pkg

/* ttc_thermal_throttle_control.sv */
// Purpose: Thermal throttle control: clock modulation and operating point lowering.
// Assumes: hot_sense is an asynchronous trip level from the die sensor.
// Notes:   Registers over APB, zero wait states, one-cycle access phase.
// Notes on behaviour
// - Trip threshold is fixed, not software set
// - Snoop continues; interrupts latched, delivered clocks-on
// - Automatic and on-demand modes; automatic wins
// - Automatic engages only at maximum temperature
// - Operating point variant requests lower point
// - After throttle, return to last requested point
// - Both variants: operating point lowering first
// - Still hot: clock modulation joins in
// - Higher load request deferred until throttle ends
// - Lower load request applied at once
// - Automatic modulation gates clocks half on
// - Modulation period shortens with core ratio
// - Cooled: automatic modulation stops, circuit deactivates unless on-demand is set
// - Hysteresis on trip release
// - Automatic duty is fixed, not writable
// - On-demand bit engages circuit at once
// - On-demand duty from bits three to one
// - Duty from one to seven eighths
// - On-demand accepted with automatic enabled
// - Readable factory diode offset register
// - Readable reference ideality used for offset
// - Automatic governs when hot and both requested
// - Active low hot indication on trip
// - Event on hot assert or deassert edge
module ttc_thermal_throttle_control #(
  parameter int         ESCALATE_CYCLES = ttc_pkg::ESCALATE_CYCLES,
  parameter logic [7:0] DIODE_OFFSET    = 8'h00  // Value is arbitrary
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Die sensor trip level
  input  wire logic        hot_sense,
  // Core interrupt path
  input  wire logic        irq_in,
  input  wire logic        irq_ack,
  output logic             irq_out,
  // Core clock and operating point control
  output logic             clock_run,
  output logic             snoop_enable,
  output logic      [7:0]  op_target,
  output logic             op_change,
  // Thermal indications
  output logic             hot_indication_n,
  output logic             hot_event
);
  localparam int ESC_W = 24;

  ttc_pkg::ttc_state_t state;
  ttc_pkg::ttc_state_t next_state;

  logic [4:0]  throttle_control;
  logic [3:0]  auto_control;
  logic [7:0]  op_request;
  logic [7:0]  op_thermal;
  logic [1:0]  event_flags;
  logic        hot_meta;
  logic        hot_sync;
  logic        hot_engaged;
  logic [15:0] hyst_count;
  logic [ESC_W-1:0] esc_count;
  logic [15:0] slot_count;
  logic [2:0]  slot_idx;
  logic        irq_latched;
  logic        apb_setup;
  logic        apb_write;
  logic        clk_var;
  logic        op_var;
  logic        demand_en;
  logic [2:0]  demand_duty;
  logic        auto_hot;
  logic        op_throttle;
  logic        modulating;
  logic [2:0]  duty;
  logic [15:0] slot_len;
  logic        next_clock_run;
  logic [7:0]  next_op_target;
  logic        load_pending;
  logic        esc_done;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  // Slot length falls linearly with the core ratio, never below one cycle
  function automatic logic [15:0] ttc_slot_len(input logic [7:0] ratio);
    logic [15:0] drop;
    drop = 16'(ratio) * ttc_pkg::SLOT_STEP;
    if (drop >= ttc_pkg::SLOT_BASE - 16'h0001)
      ttc_slot_len = 16'h0001;
    else
      ttc_slot_len = ttc_pkg::SLOT_BASE - drop;
  endfunction : ttc_slot_len

  assign clk_var     = auto_control[ttc_pkg::AUTO_CLK_BIT];
  assign op_var      = auto_control[ttc_pkg::AUTO_OP_BIT];
  assign demand_en   = throttle_control[ttc_pkg::THR_DEMAND_BIT];
  assign demand_duty = throttle_control[ttc_pkg::THR_DUTY_MSB:ttc_pkg::THR_DUTY_LSB];
  assign auto_hot    = hot_engaged && (clk_var || op_var);
  assign op_throttle = (state == ttc_pkg::TTC_AUTO_OP) || (state == ttc_pkg::TTC_AUTO_BOTH);
  assign esc_done    = esc_count == ESC_W'(ESCALATE_CYCLES - 1);

  // APB: setup captures read data, access phase completes at once
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign pready    = psel && penable;

  // Trip level passes two flip-flops; the threshold lives in the sensor
  always_ff @(posedge clock) begin
    if (reset) begin
      hot_meta <= 1'b0;
      hot_sync <= 1'b0;
    end else begin
      hot_meta <= hot_sense;
      hot_sync <= hot_meta;
    end
  end

  // Engage on trip, release only after the trip stays clear for a dwell
  always_ff @(posedge clock) begin
    if (reset) begin
      hot_engaged <= 1'b0;
      hyst_count  <= 16'h0000;
    end else if (hot_sync) begin
      hot_engaged <= 1'b1;
      hyst_count  <= 16'h0000;
    end else if (hot_engaged) begin
      if (hyst_count == 16'(ttc_pkg::HYST_CYCLES - 1)) begin
        hot_engaged <= 1'b0;
        hyst_count  <= 16'h0000;
      end else begin
        hyst_count <= hyst_count + 16'h0001;
      end
    end
  end

  // Time spent lowering the operating point while still hot
  always_ff @(posedge clock) begin
    if (reset)
      esc_count <= '0;
    else if (state != ttc_pkg::TTC_AUTO_OP)
      esc_count <= '0;
    else if (!esc_done)
      esc_count <= esc_count + ESC_W'(1);
  end

  always_comb begin
    next_state = ttc_pkg::TTC_IDLE;
    case (state)
      ttc_pkg::TTC_AUTO_OP: begin
        if (!auto_hot)
          next_state = demand_en ? ttc_pkg::TTC_DEMAND : ttc_pkg::TTC_IDLE;
        else if (!op_var)
          next_state = ttc_pkg::TTC_AUTO_MOD;
        else if (clk_var && esc_done)
          next_state = ttc_pkg::TTC_AUTO_BOTH;
        else
          next_state = ttc_pkg::TTC_AUTO_OP;
      end
      ttc_pkg::TTC_AUTO_BOTH: begin
        if (!auto_hot)
          next_state = demand_en ? ttc_pkg::TTC_DEMAND : ttc_pkg::TTC_IDLE;
        else if (!op_var)
          next_state = ttc_pkg::TTC_AUTO_MOD;
        else if (!clk_var)
          next_state = ttc_pkg::TTC_AUTO_OP;
        else
          next_state = ttc_pkg::TTC_AUTO_BOTH;
      end
      default: begin
        if (auto_hot && op_var)
          next_state = ttc_pkg::TTC_AUTO_OP;
        else if (auto_hot)
          next_state = ttc_pkg::TTC_AUTO_MOD;
        else if (demand_en)
          next_state = ttc_pkg::TTC_DEMAND;
        else
          next_state = ttc_pkg::TTC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset)
      state <= ttc_pkg::TTC_IDLE;
    else
      state <= next_state;
  end

  // Modulation: eight slots per period, duty gives slots with clocks on
  assign modulating = (state == ttc_pkg::TTC_AUTO_MOD) || (state == ttc_pkg::TTC_AUTO_BOTH) ||
                      ((state == ttc_pkg::TTC_DEMAND) && (demand_duty != 3'h0));
  assign duty       = (state == ttc_pkg::TTC_DEMAND) ? demand_duty
                                                      : ttc_pkg::AUTO_DUTY;
  assign slot_len   = ttc_slot_len(op_target);

  always_ff @(posedge clock) begin
    if (reset || !modulating) begin
      slot_count <= 16'h0000;
      slot_idx   <= 3'h0;
    end else if (slot_count >= slot_len - 16'h0001) begin
      slot_count <= 16'h0000;
      slot_idx   <= slot_idx + 3'h1;
    end else begin
      slot_count <= slot_count + 16'h0001;
    end
  end

  assign next_clock_run = !modulating || (slot_idx < duty);

  always_ff @(posedge clock) begin
    if (reset)
      clock_run <= 1'b1;
    else
      clock_run <= next_clock_run;
  end

  // Operating point: thermal target caps the load request during a throttle
  assign load_pending   = op_throttle && (op_request > op_thermal);
  assign next_op_target = load_pending ? op_thermal
                                       : op_request;

  always_ff @(posedge clock) begin
    if (reset) begin
      op_target <= ttc_pkg::OP_REQUEST_RESET;
      op_change <= 1'b0;
    end else begin
      op_target <= next_op_target;
      op_change <= next_op_target != op_target;
    end
  end

  // Interrupts latched during clock-off slots, handed on while clocks run
  always_ff @(posedge clock) begin
    if (reset)
      irq_latched <= 1'b0;
    else if (irq_in)
      irq_latched <= 1'b1;
    else if (irq_ack && irq_out)
      irq_latched <= 1'b0;
  end

  assign irq_out = irq_latched && clock_run;

  always_ff @(posedge clock) begin
    if (reset)
      snoop_enable <= 1'b0;
    else
      snoop_enable <= 1'b1;
  end

  // Hot indication and edge events
  always_ff @(posedge clock) begin
    if (reset) begin
      hot_indication_n <= 1'b1;
      hot_event        <= 1'b0;
    end else begin
      hot_indication_n <= !hot_engaged;
      hot_event        <= (hot_engaged && hot_indication_n &&
                           auto_control[ttc_pkg::AUTO_IRQ_ON_BIT]) ||
                          (!hot_engaged && !hot_indication_n &&
                           auto_control[ttc_pkg::AUTO_IRQ_OFF_BIT]);
    end
  end

  // Writable registers
  always_ff @(posedge clock) begin
    if (reset) begin
      throttle_control <= ttc_pkg::THROTTLE_RESET;
      auto_control     <= ttc_pkg::AUTO_RESET;
      op_request       <= ttc_pkg::OP_REQUEST_RESET;
      op_thermal       <= ttc_pkg::OP_THERMAL_RESET;
    end else if (apb_write) begin
      case (paddr)
        ttc_pkg::ADDR_THROTTLE:   throttle_control <= {pwdata[4:1], 1'b0};
        ttc_pkg::ADDR_AUTO:       auto_control     <= pwdata[3:0];
        ttc_pkg::ADDR_OP_REQUEST: op_request       <= pwdata[7:0];
        ttc_pkg::ADDR_OP_THERMAL: op_thermal       <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Edge flags: write one to clear, a new edge wins over the clear
  always_ff @(posedge clock) begin
    if (reset) begin
      event_flags <= 2'h0;
    end else begin
      if (hot_engaged && hot_indication_n && auto_control[ttc_pkg::AUTO_IRQ_ON_BIT])
        event_flags[ttc_pkg::EVT_ON_BIT] <= 1'b1;
      else if (apb_write && paddr == ttc_pkg::ADDR_EVENTS && pwdata[ttc_pkg::EVT_ON_BIT])
        event_flags[ttc_pkg::EVT_ON_BIT] <= 1'b0;
      if (!hot_engaged && !hot_indication_n && auto_control[ttc_pkg::AUTO_IRQ_OFF_BIT])
        event_flags[ttc_pkg::EVT_OFF_BIT] <= 1'b1;
      else if (apb_write && paddr == ttc_pkg::ADDR_EVENTS && pwdata[ttc_pkg::EVT_OFF_BIT])
        event_flags[ttc_pkg::EVT_OFF_BIT] <= 1'b0;
    end
  end

  // Read data prepared in the setup cycle
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      ttc_pkg::ADDR_THROTTLE:   next_prdata = {27'h0, throttle_control};
      ttc_pkg::ADDR_AUTO:       next_prdata = {28'h0, auto_control};
      ttc_pkg::ADDR_OP_REQUEST: next_prdata = {24'h0, op_request};
      ttc_pkg::ADDR_OP_THERMAL: next_prdata = {24'h0, op_thermal};
      ttc_pkg::ADDR_STATUS:     next_prdata = {16'h0, op_target, 2'h0, clock_run,
                                               load_pending, modulating, op_throttle,
                                               state != ttc_pkg::TTC_IDLE, hot_engaged};
      ttc_pkg::ADDR_EVENTS:     next_prdata = {30'h0, event_flags};
      ttc_pkg::ADDR_DIODE:      next_prdata = {24'h0, DIODE_OFFSET};
      ttc_pkg::ADDR_IDEALITY:   next_prdata = {16'h0, ttc_pkg::REF_IDEALITY};
      default:                  next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Checks
  sequence demand_write_s;
    apb_write && paddr == ttc_pkg::ADDR_THROTTLE && pwdata[ttc_pkg::THR_DEMAND_BIT];
  endsequence

  sequence lower_write_s;
    apb_write && paddr == ttc_pkg::ADDR_OP_REQUEST && pwdata[7:0] < op_thermal;
  endsequence

  hot_pin_a: assert property (@(posedge clock) disable iff (reset)
    $rose(hot_sync) |-> ##[1:2] !hot_indication_n)
    else $error("hot indication not asserted after trip");

  hyst_hold_a: assert property (@(posedge clock) disable iff (reset)
    $fell(hot_sync) |-> hot_engaged [*8])
    else $error("trip released without dwell");

  demand_now_a: assert property (@(posedge clock) disable iff (reset)
    demand_write_s ##1 !auto_hot |=> state != ttc_pkg::TTC_IDLE)
    else $error("on-demand write did not engage");

  auto_wins_a: assert property (@(posedge clock) disable iff (reset)
    (auto_hot && demand_en) [*2] |-> state != ttc_pkg::TTC_DEMAND)
    else $error("on-demand governs while automatic is hot");

  op_first_a: assert property (@(posedge clock) disable iff (reset)
    $rose(auto_hot) && op_var && clk_var |=> state == ttc_pkg::TTC_AUTO_OP)
    else $error("operating point variant not applied first");

  defer_high_a: assert property (@(posedge clock) disable iff (reset)
    load_pending [*2] |-> op_target == $past(op_thermal))
    else $error("higher load request not deferred");

  lower_now_a: assert property (@(posedge clock) disable iff (reset)
    lower_write_s ##1 op_throttle [*2] |-> op_target == op_request)
    else $error("lower load request not applied");

  restore_point_a: assert property (@(posedge clock) disable iff (reset)
    $fell(op_throttle) |=> op_target == $past(op_request))
    else $error("no return to requested point");

  idle_clocks_a: assert property (@(posedge clock) disable iff (reset)
    state == ttc_pkg::TTC_IDLE [*2] |-> clock_run)
    else $error("clocks gated while inactive");

  half_duty_a: assert property (@(posedge clock) disable iff (reset)
    state == ttc_pkg::TTC_AUTO_MOD && $rose(slot_idx == 3'h4) |=> !clock_run)
    else $error("automatic modulation not half on");

  irq_keep_a: assert property (@(posedge clock) disable iff (reset)
    irq_latched && !clock_run |=> irq_latched)
    else $error("interrupt lost while clocks off");

  edge_flag_a: assert property (@(posedge clock) disable iff (reset)
    $rose(hot_engaged) && auto_control[ttc_pkg::AUTO_IRQ_ON_BIT] |=> event_flags[ttc_pkg::EVT_ON_BIT])
    else $error("assert edge not flagged");
endmodule : ttc_thermal_throttle_control

/* ttc_core_model.sv */
// Purpose: Core-side model: applies operating points and takes interrupts.
// Assumes: Same clock as the throttle block.
// Notes:   An interrupt is taken with a one-cycle acknowledge pulse.
module ttc_core_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // From the throttle block
  input  wire logic [7:0] op_target,
  input  wire logic       op_change,
  input  wire logic       irq_out,
  // To the throttle block
  output logic            irq_ack,
  // Observed state
  output logic      [7:0] applied_op,
  output int              serviced
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_ack    <= 1'b0;
      applied_op <= 8'h0C;
      serviced   <= 0;
    end else begin
      irq_ack <= irq_out & ~irq_ack;
      if (irq_out & ~irq_ack) begin
        serviced <= serviced + 1;
      end
      if (op_change) begin
        applied_op <= op_target;
      end
    end
  end
endmodule : ttc_core_model

/* thermal_throttle_control_test.sv */
// Purpose: Self-checking bench of the thermal throttle block.
// Assumes: Escalation dwell shortened to 50 cycles.
// Notes:   Duty is measured by counting clock-on cycles over whole periods.
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module thermal_throttle_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DIODE_VAL = 8'h5A;  // Value is arbitrary
  logic        clock, reset, psel, penable, pwrite, hot_sense, irq_in;
  logic [7:0]  paddr, op_target, applied_op;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq_ack, irq_out, clock_run, snoop_enable;
  logic        op_change, hot_indication_n, hot_event;
  int          serviced, miscompares, cmp_count, cycle_count, evt_count, on, len;
  logic [31:0] q;
  logic        e;

  ttc_thermal_throttle_control #(.ESCALATE_CYCLES(50), .DIODE_OFFSET(DIODE_VAL))
    u_ttc_thermal_throttle_control (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hot_sense(hot_sense), .irq_in(irq_in),
    .irq_ack(irq_ack), .irq_out(irq_out), .clock_run(clock_run),
    .snoop_enable(snoop_enable), .op_target(op_target), .op_change(op_change),
    .hot_indication_n(hot_indication_n), .hot_event(hot_event));
  ttc_core_model u_ttc_core_model (.clock(clock), .reset(reset), .op_target(op_target),
    .op_change(op_change), .irq_out(irq_out), .irq_ack(irq_ack),
    .applied_op(applied_op), .serviced(serviced));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycle_count++;
    if (hot_event === 1'b1) evt_count++;
    if (cycle_count == 60000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                    input logic xe);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", x, q & m)
    `CHK("pslverr", xe, e)
  endtask : rd

  function automatic logic sig(input int s);
    return s == 0 ? clock_run : (s == 1 ? hot_indication_n : irq_out);
  endfunction : sig

  task automatic wait_sig(input int s, input logic v, input int n);
    int i;
    i = 0;
    while (sig(s) !== v && i < n) begin
      @(posedge clock);
      i++;
    end
    `CHK("wait", v, sig(s))
  endtask : wait_sig

  task automatic count_on(input int skip, input int n);
    repeat (skip) @(posedge clock);
    on = 0;
    repeat (n) begin
      @(posedge clock);
      if (clock_run === 1'b1) on++;
    end
  endtask : count_on

  task automatic off_run();
    // Skip any off run cut short by the last setting change
    wait_sig(0, 1'b0, 2000);
    wait_sig(0, 1'b1, 2000);
    wait_sig(0, 1'b0, 2000);
    len = 0;
    while (clock_run === 1'b0 && len < 2000) begin
      @(posedge clock);
      len++;
    end
  endtask : off_run

  task automatic t_regs();
    rd(8'h00, 32'hFFFFFFFF, 32'h00, 1'b0);
    rd(8'h04, 32'hFFFFFFFF, 32'h03, 1'b0);
    rd(8'h08, 32'hFFFFFFFF, 32'h0C, 1'b0);
    rd(8'h0C, 32'hFFFFFFFF, 32'h06, 1'b0);
    apb(1'b1, 8'h18, 32'hFF);
    rd(8'h18, 32'hFFFFFFFF, {24'h0, DIODE_VAL}, 1'b0);
    apb(1'b1, 8'h1C, 32'h0);
    rd(8'h1C, 32'hFFFFFFFF, 32'h65, 1'b0);
    rd(8'h40, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'h1F);
    rd(8'h00, 32'hFFFFFFFF, 32'h1E, 1'b0);
    `CHK("snoop_enable", 1'b1, snoop_enable)
    $display("test registers done");
  endtask : t_regs

  task automatic t_demand();
    apb(1'b1, 8'h08, 32'h3F);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 8'h00, {27'h0, 1'b1, k[2:0], 1'b0});
      count_on(256, 128);
      `CHK("on cycles", (k == 0) ? 128 : k * 16, on)
    end
    apb(1'b1, 8'h00, 32'h18);
    off_run();
    `CHK("off run", 64, len)
    apb(1'b1, 8'h08, 32'h3E);
    off_run();
    off_run();
    `CHK("off run", 128, len)
    $display("test on-demand done");
  endtask : t_demand

  task automatic t_auto_mod();
    apb(1'b1, 8'h08, 32'h3F);
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h04, 32'h0D);
    count_on(300, 128);
    `CHK("on cycles", 128, on)
    apb(1'b1, 8'h00, 32'h12);
    evt_count = 0;
    hot_sense <= 1'b1;
    wait_sig(1, 1'b0, 10);
    count_on(256, 128);
    `CHK("hot_event", 1, evt_count)
    `CHK("on cycles", 64, on)
    rd(8'h14, 32'h3, 32'h1, 1'b0);
    hot_sense <= 1'b0;
    repeat (900) @(posedge clock);
    `CHK("hot_indication_n", 1'b0, hot_indication_n)
    wait_sig(1, 1'b1, 300);
    rd(8'h14, 32'h3, 32'h3, 1'b0);
    apb(1'b1, 8'h14, 32'h3);
    rd(8'h14, 32'h3, 32'h0, 1'b0);
    count_on(256, 128);
    `CHK("on cycles", 16, on)
    apb(1'b1, 8'h00, 32'h00);
    $display("test automatic modulation done");
  endtask : t_auto_mod

  task automatic t_auto_op();
    apb(1'b1, 8'h08, 32'h0C);
    apb(1'b1, 8'h04, 32'h03);
    hot_sense <= 1'b1;
    wait_sig(1, 1'b0, 10);
    count_on(3, 40);
    `CHK("on cycles", 40, on)
    `CHK("op_target", 8'h06, op_target)
    `CHK("applied_op", 8'h06, applied_op)
    apb(1'b1, 8'h08, 32'h10);
    rd(8'h10, 32'h10, 32'h10, 1'b0);
    `CHK("op_target", 8'h06, op_target)
    apb(1'b1, 8'h08, 32'h04);
    repeat (3) @(posedge clock);
    `CHK("op_target", 8'h04, op_target)
    apb(1'b1, 8'h08, 32'h10);
    repeat (3) @(posedge clock);
    `CHK("op_target", 8'h06, op_target)
    wait_sig(0, 1'b0, 5000);
    hot_sense <= 1'b0;
    wait_sig(1, 1'b1, 1200);
    repeat (4) @(posedge clock);
    `CHK("op_target", 8'h10, op_target)
    `CHK("clock_run", 1'b1, clock_run)
    $display("test operating point done");
  endtask : t_auto_op

  task automatic t_irq();
    apb(1'b1, 8'h04, 32'h00);
    apb(1'b1, 8'h08, 32'h3F);
    apb(1'b1, 8'h00, 32'h12);
    wait_sig(0, 1'b0, 300);
    irq_in <= 1'b1;
    @(posedge clock);
    irq_in <= 1'b0;
    count_on(0, 10);
    `CHK("irq_out", 1'b0, irq_out)
    wait_sig(2, 1'b1, 200);
    `CHK("clock_run", 1'b1, clock_run)
    repeat (3) @(posedge clock);
    `CHK("serviced", 1, serviced)
    `CHK("snoop_enable", 1'b1, snoop_enable)
    $display("test interrupt latch done");
  endtask : t_irq

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, hot_sense, irq_in} = 5'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    {miscompares, cmp_count, cycle_count, evt_count} = 0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_demand();
    t_auto_mod();
    t_auto_op();
    t_irq();
    results();
  end
endmodule : thermal_throttle_control_test
